// *** src/rfd_params.svh ***
// Field positions, widths and reset values of the instruction format decoder
`ifndef RFD_PARAMS_SVH
`define RFD_PARAMS_SVH

// Word and result widths
`define RFD_WORD_W 16
`define RFD_DATA_W 32

// Field positions inside the instruction word
`define RFD_OPC_MSB 15
`define RFD_OPC_LSB 12
`define RFD_RN_MSB 11
`define RFD_RN_LSB 8
`define RFD_RM_MSB 7
`define RFD_RM_LSB 4
`define RFD_D4_MSB 3
`define RFD_D8_MSB 7
`define RFD_D12_MSB 11
`define RFD_FLD_LSB 0

// Reset values of the registered outputs
`define RFD_RST_REG 4'h0
`define RFD_RST_DATA 32'h0000_0000

`endif

// *** src/rfd_pkg.sv ***
// Types shared by the instruction format decoder
package rfd_pkg;

  // Instruction formats
  typedef enum logic [3:0] {
    FMT_ZERO = 4'h0,
    FMT_N = 4'h1,
    FMT_M = 4'h2,
    FMT_NM = 4'h3,
    FMT_MD = 4'h4,
    FMT_ND4 = 4'h5,
    FMT_NMD = 4'h6,
    FMT_D = 4'h7,
    FMT_D12 = 4'h8,
    FMT_ND8 = 4'h9,
    FMT_I = 4'hA,
    FMT_NI = 4'hB,
    FMT_ILLEGAL = 4'hF
  } rfd_fmt_t;

  // Operand addressing classes
  typedef enum logic [3:0] {
    MODE_NONE = 4'h0,
    MODE_DIRECT = 4'h1,
    MODE_INDIRECT = 4'h2,
    MODE_POSTINC = 4'h3,
    MODE_PREDEC = 4'h4,
    MODE_INDEXED = 4'h5,
    MODE_DISP_REG = 4'h6,
    MODE_GBR_DISP = 4'h7,
    MODE_GBR_INDEXED = 4'h8,
    MODE_PC_DISP = 4'h9,
    MODE_PC_REL = 4'hA,
    MODE_IMM = 4'hB,
    MODE_CTRL_SYS = 4'hC,
    MODE_MUL_ACC = 4'hD
  } rfd_mode_t;

  // Access sizes
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } rfd_size_t;

endpackage : rfd_pkg

// *** src/rfd_decoder.sv ***
// Instruction format decoder: fields and operand classes of 16-bit instruction words
`timescale 1ns/1ps
`default_nettype none
`include "rfd_params.svh"

// Behaviour
// RL1: 16-bit word, opcode picks field meaning
// RL2: n format: bits 11:8 destination register
// RL3: m format: bits 11:8 source register
// RL4: m format: PC-relative branch via register
// RL5: nm format: destination 11:8, source 7:4
// RL6: Multiply-accumulate: both fields post-increment sources; code classes source MODE_POSTINC, destination MODE_MUL_ACC
// RL7: md format: base 7:4, disp 3:0, R0 destination
// RL8: nd4 format: base 7:4, disp 3:0, R0 source
// RL9: nmd format: two registers plus 4-bit displacement
// RL10: d format: 8-bit GLOBAL_BASE_REGISTER, PC or branch displacement
// RL11: d12 format: 12-bit PC-relative branch
// RL12: nd8 format: register plus PC-relative displacement
// RL13: i format: 8-bit immediate, R0/GLOBAL_BASE_REGISTER/none destination
// RL14: ni format: register plus 8-bit immediate
// RL15: Immediate zero, sign or trap-scaled extension
// RL16: Data displacements zero-extended, scaled by size
// RL17: Branch displacements sign-extended and doubled
// RL18: Format and fields decoded per fetched word
module rfd_decoder (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // Fetched instruction
  input wire logic [`RFD_WORD_W-1:0] INSTR_I,
  input wire logic INSTR_VALID_I,
  // Decoded format and operand classes
  output logic VALID_O,
  output logic ILLEGAL_O,
  output logic [3:0] FORMAT_O,
  output logic [3:0] SRC_MODE_O,
  output logic [3:0] DST_MODE_O,
  output logic [1:0] SIZE_O,
  output logic MAC_O,
  // Decoded fields
  output logic [3:0] RN_O,
  output logic [3:0] RM_O,
  output logic [`RFD_DATA_W-1:0] DISP_O,
  output logic [`RFD_DATA_W-1:0] IMM_O
);

  rfd_pkg::rfd_fmt_t fmt, next_fmt;
  rfd_pkg::rfd_mode_t src, next_src, dst, next_dst;
  rfd_pkg::rfd_size_t size, next_size;
  logic valid, next_valid;
  logic mac, next_mac;
  logic illegal, next_illegal;
  logic [3:0] rn, next_rn, rm, next_rm;
  logic [`RFD_DATA_W-1:0] disp, next_disp, imm, next_imm;

  // Zero-extend and scale a data displacement by access size
  function automatic logic [`RFD_DATA_W-1:0] zscale(input logic [7:0] d, input rfd_pkg::rfd_size_t sz);
    logic [`RFD_DATA_W-1:0] z;
    z = {24'h00_0000, d};
    zscale = z << sz; // RL16
  endfunction : zscale

  // Field decode of the fetched word
  always_comb begin
    logic [3:0] f_n;
    logic [3:0] f_m;
    logic [3:0] f_lo;
    logic [7:0] f_d8;
    logic [11:0] f_d12;
    f_n = INSTR_I[`RFD_RN_MSB:`RFD_RN_LSB]; // RL1
    f_m = INSTR_I[`RFD_RM_MSB:`RFD_RM_LSB];
    f_lo = INSTR_I[`RFD_D4_MSB:`RFD_FLD_LSB];
    f_d8 = INSTR_I[`RFD_D8_MSB:`RFD_FLD_LSB];
    f_d12 = INSTR_I[`RFD_D12_MSB:`RFD_FLD_LSB];
    next_valid = INSTR_VALID_I; // RL18
    next_fmt = rfd_pkg::FMT_ILLEGAL;
    next_src = rfd_pkg::MODE_NONE;
    next_dst = rfd_pkg::MODE_NONE;
    next_size = rfd_pkg::SZ_LONG;
    next_mac = 1'b0;
    next_rn = f_n;
    next_rm = f_m;
    next_disp = `RFD_DATA_W'(0);
    next_imm = `RFD_DATA_W'(0);
    unique case (INSTR_I[`RFD_OPC_MSB:`RFD_OPC_LSB])
      4'h0: begin
        unique case (f_lo)
          4'h2, 4'hA: begin
            if (f_m <= 4'h2) begin
              next_fmt = rfd_pkg::FMT_N; // RL2
              next_src = rfd_pkg::MODE_CTRL_SYS;
              next_dst = rfd_pkg::MODE_DIRECT;
            end
          end
          4'h3: begin
            if (f_m == 4'h0 || f_m == 4'h2) begin
              next_fmt = rfd_pkg::FMT_M;
              next_rm = f_n;
              next_src = rfd_pkg::MODE_PC_REL; // RL4
            end
          end
          4'h4, 4'h5, 4'h6: begin
            next_fmt = rfd_pkg::FMT_NM;
            next_src = rfd_pkg::MODE_DIRECT;
            next_dst = rfd_pkg::MODE_INDEXED; // RL5
            next_size = rfd_pkg::rfd_size_t'(f_lo[1:0]);
          end
          4'hC, 4'hD, 4'hE: begin
            next_fmt = rfd_pkg::FMT_NM;
            next_src = rfd_pkg::MODE_INDEXED;
            next_dst = rfd_pkg::MODE_DIRECT;
            next_size = rfd_pkg::rfd_size_t'(f_lo[1:0]);
          end
          4'h7: begin
            next_fmt = rfd_pkg::FMT_NM;
            next_src = rfd_pkg::MODE_DIRECT;
            next_dst = rfd_pkg::MODE_MUL_ACC;
          end
          4'hF: begin
            next_fmt = rfd_pkg::FMT_NM;
            next_src = rfd_pkg::MODE_POSTINC; // RL6
            next_dst = rfd_pkg::MODE_MUL_ACC;
            next_mac = 1'b1;
          end
          4'h9: begin
            if (f_m == 4'h2) begin
              next_fmt = rfd_pkg::FMT_N;
              next_dst = rfd_pkg::MODE_DIRECT;
            end else if (f_n == 4'h0 && f_m <= 4'h2) begin
              next_fmt = rfd_pkg::FMT_ZERO;
            end
          end
          4'h8, 4'hB: begin
            if (f_n == 4'h0 && f_m <= 4'h2) begin
              next_fmt = rfd_pkg::FMT_ZERO;
            end
          end
          default: begin
          end
        endcase
      end
      4'h1: begin
        next_fmt = rfd_pkg::FMT_NMD; // RL9
        next_src = rfd_pkg::MODE_DIRECT;
        next_dst = rfd_pkg::MODE_DISP_REG;
        next_disp = zscale({4'h0, f_lo}, rfd_pkg::SZ_LONG);
      end
      4'h5: begin
        next_fmt = rfd_pkg::FMT_NMD; // RL9
        next_src = rfd_pkg::MODE_DISP_REG;
        next_dst = rfd_pkg::MODE_DIRECT;
        next_disp = zscale({4'h0, f_lo}, rfd_pkg::SZ_LONG);
      end
      4'h2, 4'h3, 4'h6: begin
        next_fmt = rfd_pkg::FMT_NM; // RL5
        next_src = rfd_pkg::MODE_DIRECT;
        next_dst = rfd_pkg::MODE_DIRECT;
        if (!INSTR_I[12] && !f_lo[3] && f_lo[1:0] != 2'h3) begin // Bit 12 keeps arithmetic words direct
          next_size = rfd_pkg::rfd_size_t'(f_lo[1:0]);
          if (!INSTR_I[14]) begin
            next_dst = f_lo[2] ? rfd_pkg::MODE_PREDEC : rfd_pkg::MODE_INDIRECT;
          end else begin
            next_src = f_lo[2] ? rfd_pkg::MODE_POSTINC : rfd_pkg::MODE_INDIRECT;
          end
        end else if (!INSTR_I[12] && f_lo == 4'h3 && !INSTR_I[14]) begin
          next_fmt = rfd_pkg::FMT_ILLEGAL;
          next_src = rfd_pkg::MODE_NONE;
          next_dst = rfd_pkg::MODE_NONE;
        end else if (INSTR_I[12] && (f_lo == 4'h1 || f_lo == 4'h9)) begin
          next_fmt = rfd_pkg::FMT_ILLEGAL;
          next_src = rfd_pkg::MODE_NONE;
          next_dst = rfd_pkg::MODE_NONE;
        end
      end
      4'h4: begin
        if (f_lo == 4'hF) begin
          next_fmt = rfd_pkg::FMT_NM;
          next_src = rfd_pkg::MODE_POSTINC; // RL6
          next_dst = rfd_pkg::MODE_MUL_ACC;
          next_size = rfd_pkg::SZ_WORD;
          next_mac = 1'b1;
        end else begin
          unique case (f_d8)
            8'h00, 8'h01, 8'h04, 8'h05, 8'h08, 8'h09, 8'h10, 8'h11, 8'h15, 8'h18, 8'h19, 8'h20, 8'h21,
            8'h24, 8'h25, 8'h28, 8'h29: begin
              next_fmt = rfd_pkg::FMT_N; // RL2
              next_dst = rfd_pkg::MODE_DIRECT;
            end
            8'h02, 8'h03, 8'h12, 8'h13, 8'h22, 8'h23: begin
              next_fmt = rfd_pkg::FMT_N;
              next_src = rfd_pkg::MODE_CTRL_SYS;
              next_dst = rfd_pkg::MODE_PREDEC; // RL2
            end
            8'h1B: begin
              next_fmt = rfd_pkg::FMT_N;
              next_dst = rfd_pkg::MODE_INDIRECT;
              next_size = rfd_pkg::SZ_BYTE;
            end
            8'h06, 8'h07, 8'h16, 8'h17, 8'h26, 8'h27: begin
              next_fmt = rfd_pkg::FMT_M;
              next_rm = f_n;
              next_src = rfd_pkg::MODE_POSTINC; // RL3
              next_dst = rfd_pkg::MODE_CTRL_SYS;
            end
            8'h0A, 8'h0E, 8'h1A, 8'h1E, 8'h2A, 8'h2E: begin
              next_fmt = rfd_pkg::FMT_M;
              next_rm = f_n;
              next_src = rfd_pkg::MODE_DIRECT; // RL3
              next_dst = rfd_pkg::MODE_CTRL_SYS;
            end
            8'h0B, 8'h2B: begin
              next_fmt = rfd_pkg::FMT_M;
              next_rm = f_n;
              next_src = rfd_pkg::MODE_DIRECT; // RL3
            end
            default: begin
            end
          endcase
        end
      end
      4'h7, 4'hE: begin
        next_fmt = rfd_pkg::FMT_NI; // RL14
        next_src = rfd_pkg::MODE_IMM;
        next_dst = rfd_pkg::MODE_DIRECT;
        next_imm = {{24{f_d8[7]}}, f_d8}; // RL15
      end
      4'h8: begin
        next_rn = 4'h0;
        next_rm = 4'h0;
        unique case (f_n)
          4'h0, 4'h1: begin
            next_fmt = rfd_pkg::FMT_ND4; // RL8
            next_rn = f_m;
            next_src = rfd_pkg::MODE_DIRECT;
            next_dst = rfd_pkg::MODE_DISP_REG;
            next_size = rfd_pkg::rfd_size_t'({1'b0, f_n[0]});
            next_disp = zscale({4'h0, f_lo}, rfd_pkg::rfd_size_t'({1'b0, f_n[0]})); // RL16
          end
          4'h4, 4'h5: begin
            next_fmt = rfd_pkg::FMT_MD; // RL7
            next_rm = f_m;
            next_src = rfd_pkg::MODE_DISP_REG;
            next_dst = rfd_pkg::MODE_DIRECT;
            next_size = rfd_pkg::rfd_size_t'({1'b0, f_n[0]});
            next_disp = zscale({4'h0, f_lo}, rfd_pkg::rfd_size_t'({1'b0, f_n[0]})); // RL16
          end
          4'h8: begin
            next_fmt = rfd_pkg::FMT_I; // RL13
            next_src = rfd_pkg::MODE_IMM;
            next_dst = rfd_pkg::MODE_DIRECT;
            next_imm = {{24{f_d8[7]}}, f_d8}; // RL15
          end
          4'h9, 4'hB, 4'hD, 4'hF: begin
            next_fmt = rfd_pkg::FMT_D; // RL10
            next_src = rfd_pkg::MODE_PC_REL;
            next_disp = {{23{f_d8[7]}}, f_d8, 1'b0}; // RL17
          end
          default: begin
          end
        endcase
      end
      4'h9, 4'hD: begin
        next_fmt = rfd_pkg::FMT_ND8; // RL12
        next_rm = 4'h0;
        next_src = rfd_pkg::MODE_PC_DISP;
        next_dst = rfd_pkg::MODE_DIRECT;
        next_size = INSTR_I[14] ? rfd_pkg::SZ_LONG : rfd_pkg::SZ_WORD;
        next_disp = zscale(f_d8, INSTR_I[14] ? rfd_pkg::SZ_LONG : rfd_pkg::SZ_WORD);
      end
      4'hA, 4'hB: begin
        next_fmt = rfd_pkg::FMT_D12; // RL11
        next_rn = 4'h0;
        next_rm = 4'h0;
        next_src = rfd_pkg::MODE_PC_REL;
        next_disp = {{19{f_d12[11]}}, f_d12, 1'b0}; // RL17
      end
      4'hC: begin
        next_rn = 4'h0;
        next_rm = 4'h0;
        next_size = rfd_pkg::rfd_size_t'(f_n[1:0]);
        unique case (f_n)
          4'h0, 4'h1, 4'h2: begin
            next_fmt = rfd_pkg::FMT_D; // RL10
            next_src = rfd_pkg::MODE_DIRECT;
            next_dst = rfd_pkg::MODE_GBR_DISP;
            next_disp = zscale(f_d8, rfd_pkg::rfd_size_t'(f_n[1:0]));
          end
          4'h4, 4'h5, 4'h6: begin
            next_fmt = rfd_pkg::FMT_D; // RL10
            next_src = rfd_pkg::MODE_GBR_DISP;
            next_dst = rfd_pkg::MODE_DIRECT;
            next_disp = zscale(f_d8, rfd_pkg::rfd_size_t'(f_n[1:0]));
          end
          4'h7: begin
            next_fmt = rfd_pkg::FMT_D; // RL10
            next_src = rfd_pkg::MODE_PC_DISP;
            next_dst = rfd_pkg::MODE_DIRECT;
            next_size = rfd_pkg::SZ_LONG;
            next_disp = zscale(f_d8, rfd_pkg::SZ_LONG);
          end
          4'h3: begin
            next_fmt = rfd_pkg::FMT_I; // RL13
            next_src = rfd_pkg::MODE_IMM;
            next_size = rfd_pkg::SZ_LONG; // Sub-op 3 is no access size
            next_imm = zscale(f_d8, rfd_pkg::SZ_LONG); // RL15
          end
          4'h8, 4'h9, 4'hA, 4'hB: begin
            next_fmt = rfd_pkg::FMT_I; // RL13
            next_src = rfd_pkg::MODE_IMM;
            next_dst = rfd_pkg::MODE_DIRECT;
            next_size = rfd_pkg::SZ_LONG;
            next_imm = {24'h00_0000, f_d8}; // RL15
          end
          default: begin
            next_fmt = rfd_pkg::FMT_I; // RL13
            next_src = rfd_pkg::MODE_IMM;
            next_dst = rfd_pkg::MODE_GBR_INDEXED;
            next_size = rfd_pkg::SZ_BYTE;
            next_imm = {24'h00_0000, f_d8}; // RL15
          end
        endcase
      end
      default: begin
      end
    endcase
    // Register fields with no register behind them read as zero
    if (next_fmt == rfd_pkg::FMT_ZERO || next_fmt == rfd_pkg::FMT_M) begin
      next_rn = 4'h0;
    end
    if (next_fmt == rfd_pkg::FMT_ZERO || next_fmt == rfd_pkg::FMT_N || next_fmt == rfd_pkg::FMT_NI) begin
      next_rm = 4'h0;
    end
    // Unrecognised words carry no operands
    if (next_fmt == rfd_pkg::FMT_ILLEGAL) begin
      next_rn = 4'h0;
      next_rm = 4'h0;
      next_disp = `RFD_DATA_W'(0);
      next_imm = `RFD_DATA_W'(0);
    end
    next_illegal = (next_fmt == rfd_pkg::FMT_ILLEGAL); // RL1
  end

  // Register decoded results for the next stage
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      valid <= 1'b0;
      fmt <= rfd_pkg::FMT_ILLEGAL;
      src <= rfd_pkg::MODE_NONE;
      dst <= rfd_pkg::MODE_NONE;
      size <= rfd_pkg::SZ_LONG;
      mac <= 1'b0;
      illegal <= 1'b1;
      rn <= `RFD_RST_REG;
      rm <= `RFD_RST_REG;
      disp <= `RFD_RST_DATA;
      imm <= `RFD_RST_DATA;
    end else begin
      valid <= next_valid; // RL18
      fmt <= next_fmt;
      src <= next_src;
      dst <= next_dst;
      size <= next_size;
      mac <= next_mac;
      illegal <= next_illegal;
      rn <= next_rn;
      rm <= next_rm;
      disp <= next_disp;
      imm <= next_imm;
    end
  end

  // Outputs straight from the result registers
  assign VALID_O = valid;
  assign ILLEGAL_O = illegal;
  assign FORMAT_O = fmt;
  assign SRC_MODE_O = src;
  assign DST_MODE_O = dst;
  assign SIZE_O = size;
  assign MAC_O = mac;
  assign RN_O = rn;
  assign RM_O = rm;
  assign DISP_O = disp;
  assign IMM_O = imm;

endmodule : rfd_decoder
`default_nettype wire

// *** tb/rfd_decoder_assertions.sv ***
// Checker for the instruction format decoder ports
`timescale 1ns/1ps
`default_nettype none
`include "rfd_params.svh"

module rfd_decoder_assertions (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // Fetched instruction
  input wire logic [`RFD_WORD_W-1:0] INSTR_I,
  input wire logic INSTR_VALID_I,
  // Decoded format and operand classes
  input wire logic VALID_O,
  input wire logic ILLEGAL_O,
  input wire logic [3:0] FORMAT_O,
  input wire logic [3:0] SRC_MODE_O,
  input wire logic [3:0] DST_MODE_O,
  input wire logic [1:0] SIZE_O,
  input wire logic MAC_O,
  // Decoded fields
  input wire logic [3:0] RN_O,
  input wire logic [3:0] RM_O,
  input wire logic [`RFD_DATA_W-1:0] DISP_O,
  input wire logic [`RFD_DATA_W-1:0] IMM_O
);
  // One clock domain for every property
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  // Valid follows the fetch qualifier one cycle later
  AST_VALID_LAT: assert property (INSTR_VALID_I ##1 1'b1 |-> VALID_O)
    else $error("valid did not follow qualifier");
  AST_ILLEGAL_FLAG: assert property (ILLEGAL_O == (FORMAT_O == 4'hF) && (!ILLEGAL_O || (RN_O == 4'h0 && RM_O == 4'h0
    && SRC_MODE_O == 4'h0 && DST_MODE_O == 4'h0 && DISP_O == 32'h0000_0000 && IMM_O == 32'h0000_0000)))
    else $error("illegal flag disagrees with format");
  AST_NI_FIELDS: assert property (INSTR_I[15:12] == 4'h7 |=> FORMAT_O == 4'hB && RN_O == $past(INSTR_I[11:8])
    && IMM_O == {{24{$past(INSTR_I[7])}}, $past(INSTR_I[7:0])})
    else $error("register immediate fields wrong");
  AST_D12_DISP: assert property (INSTR_I[15:13] == 3'b101 |=> FORMAT_O == 4'h8
    && DISP_O == {{19{$past(INSTR_I[11])}}, $past(INSTR_I[11:0]), 1'b0})
    else $error("long branch displacement wrong");
  AST_ND8_DISP: assert property (INSTR_I[15:12] == 4'h9 |=> FORMAT_O == 4'h9 && RN_O == $past(INSTR_I[11:8])
    && DISP_O == {23'h00_0000, $past(INSTR_I[7:0]), 1'b0})
    else $error("pc relative word displacement wrong");
  AST_NMD_LOAD: assert property (INSTR_I[15:12] == 4'h5 |=> FORMAT_O == 4'h6 && RM_O == $past(INSTR_I[7:4])
    && DISP_O == {26'h000_0000, $past(INSTR_I[3:0]), 2'b00})
    else $error("displaced longword load fields wrong");
  AST_TRAP_IMM: assert property (INSTR_I[15:8] == 8'hC3 |=> FORMAT_O == 4'hA
    && IMM_O == {22'h00_0000, $past(INSTR_I[7:0]), 2'b00})
    else $error("trap vector immediate wrong");
  AST_UNKNOWN_ZERO: assert property (INSTR_I[15:12] == 4'hF |=> ILLEGAL_O && DISP_O == 32'h0000_0000
    && IMM_O == 32'h0000_0000)
    else $error("unknown word not flagged");
  AST_MAC_SRC: assert property (INSTR_I[15:12] == 4'h4 && INSTR_I[3:0] == 4'hF |=> MAC_O
    && SRC_MODE_O == 4'h3 && DST_MODE_O == 4'hD)
    else $error("multiply accumulate classes wrong");

  // Main scenarios seen
  CVR_NI: cover property (INSTR_I[15:12] == 4'h7 ##1 FORMAT_O == 4'hB);
  CVR_D12: cover property (INSTR_I[15:13] == 3'b101 ##1 FORMAT_O == 4'h8);
  CVR_MAC: cover property (INSTR_I[15:12] == 4'h4 && INSTR_I[3:0] == 4'hF ##1 MAC_O);
endmodule : rfd_decoder_assertions

bind rfd_decoder rfd_decoder_assertions i_chk (.MCLK_I(MCLK_I), .RESET_I(RESET_I), .INSTR_I(INSTR_I),
  .INSTR_VALID_I(INSTR_VALID_I), .VALID_O(VALID_O), .ILLEGAL_O(ILLEGAL_O), .FORMAT_O(FORMAT_O),
  .SRC_MODE_O(SRC_MODE_O), .DST_MODE_O(DST_MODE_O), .SIZE_O(SIZE_O), .MAC_O(MAC_O), .RN_O(RN_O),
  .RM_O(RM_O), .DISP_O(DISP_O), .IMM_O(IMM_O));
`default_nettype wire

// *** tb/rfd_fetch_model.sv ***
// Fetch stage model that presents instruction words
`timescale 1ns/1ps
`default_nettype none

module rfd_fetch_model (
  // Presented word
  output logic [15:0] word_o,
  output logic valid_o
);
  // Idle bus at time zero
  initial begin
    word_o = 16'h0009;
    valid_o = 1'b0;
  end

  // Hand one 16-bit word to the decoder
  task automatic present(input logic [15:0] w, input logic v);
    word_o = w;
    valid_o = v;
  endtask : present

  // No word: show the inverse so a stale value never looks current
  task automatic idle();
    word_o = ~word_o;
    valid_o = 1'b0;
  endtask : idle
endmodule : rfd_fetch_model
`default_nettype wire

// *** tb/risc_instruction_format_decoder_bench.sv ***
// Self-checking bench for the instruction format decoder
`timescale 1ns/1ps
`default_nettype none

module risc_instruction_format_decoder_bench;
  logic mclk;
  logic reset;
  logic [15:0] instr;
  logic instr_valid;
  logic valid, illegal, mac;
  logic [3:0] fmt, src, dst, rn, rm;
  logic [1:0] size;
  logic [31:0] disp, imm;
  int err_total = 0;
  int checks_done = 0;

  // Clock and partner
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  rfd_fetch_model i_fetch (.word_o(instr), .valid_o(instr_valid));
  rfd_decoder i_dut (.MCLK_I(mclk), .RESET_I(reset), .INSTR_I(instr), .INSTR_VALID_I(instr_valid),
    .VALID_O(valid), .ILLEGAL_O(illegal), .FORMAT_O(fmt), .SRC_MODE_O(src), .DST_MODE_O(dst),
    .SIZE_O(size), .MAC_O(mac), .RN_O(rn), .RM_O(rm), .DISP_O(disp), .IMM_O(imm));

  // Compare one value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic conclude();
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // Present a word, let one edge pass, then judge classes and fields
  task automatic dec(input logic [15:0] w, input logic [3:0] f, s, d, n, m, input logic [31:0] dp, im);
    i_fetch.present(w, 1'b1);
    @(posedge mclk);
    #1;
    check({11'h000, valid, fmt, src, dst, rn, rm}, {11'h000, 1'b1, f, s, d, n, m});
    check(disp, dp);
    check(imm, im);
  endtask : dec

  // Register immediate, sign extended both ways
  task automatic t_ni();
    dec(16'h7105, 4'hB, 4'hB, 4'h1, 4'h1, 4'h0, 32'h0000_0000, 32'h0000_0005);
    dec(16'h7CFF, 4'hB, 4'hB, 4'h1, 4'hC, 4'h0, 32'h0000_0000, 32'hFFFF_FFFF);
  endtask : t_ni

  // Immediate only: zero extended logic and scaled trap vector
  task automatic t_imm();
    dec(16'hC9F0, 4'hA, 4'hB, 4'h1, 4'h0, 4'h0, 32'h0000_0000, 32'h0000_00F0);
    dec(16'hC3FF, 4'hA, 4'hB, 4'h0, 4'h0, 4'h0, 32'h0000_0000, 32'h0000_03FC);
  endtask : t_imm

  // Branches: long, short conditional and register relative
  task automatic t_branch();
    dec(16'hA800, 4'h8, 4'hA, 4'h0, 4'h0, 4'h0, 32'hFFFF_F000, 32'h0000_0000);
    dec(16'hA7FF, 4'h8, 4'hA, 4'h0, 4'h0, 4'h0, 32'h0000_0FFE, 32'h0000_0000);
    dec(16'h8BFE, 4'h7, 4'hA, 4'h0, 4'h0, 4'h0, 32'hFFFF_FFFC, 32'h0000_0000);
    dec(16'h0323, 4'h2, 4'hA, 4'h0, 4'h0, 4'h3, 32'h0000_0000, 32'h0000_0000);
  endtask : t_branch

  // Control register store and load
  task automatic t_ctrl();
    dec(16'h4103, 4'h1, 4'hC, 4'h4, 4'h1, 4'h0, 32'h0000_0000, 32'h0000_0000);
    dec(16'h4207, 4'h2, 4'h3, 4'hC, 4'h0, 4'h2, 32'h0000_0000, 32'h0000_0000);
  endtask : t_ctrl

  // Two register forms and multiply accumulate
  task automatic t_nm();
    dec(16'h2132, 4'h3, 4'h1, 4'h2, 4'h1, 4'h3, 32'h0000_0000, 32'h0000_0000);
    check({30'h0000_0000, size}, 32'h0000_0002);
    dec(16'h0124, 4'h3, 4'h1, 4'h5, 4'h1, 4'h2, 32'h0000_0000, 32'h0000_0000);
    dec(16'h412F, 4'h3, 4'h3, 4'hD, 4'h1, 4'h2, 32'h0000_0000, 32'h0000_0000);
    check({31'h0000_0000, mac}, 32'h0000_0001);
  endtask : t_nm

  // Register displacement forms, scaled by size
  task automatic t_disp();
    dec(16'h8435, 4'h4, 4'h6, 4'h1, 4'h0, 4'h3, 32'h0000_0005, 32'h0000_0000);
    dec(16'h8135, 4'h5, 4'h1, 4'h6, 4'h3, 4'h0, 32'h0000_000A, 32'h0000_0000);
    dec(16'h512F, 4'h6, 4'h6, 4'h1, 4'h1, 4'h2, 32'h0000_003C, 32'h0000_0000);
    dec(16'h1123, 4'h6, 4'h1, 4'h6, 4'h1, 4'h2, 32'h0000_000C, 32'h0000_0000);
    dec(16'hC5FF, 4'h7, 4'h7, 4'h1, 4'h0, 4'h0, 32'h0000_01FE, 32'h0000_0000);
  endtask : t_disp

  // PC relative data, no-operand and unknown words
  task automatic t_misc();
    dec(16'h9105, 4'h9, 4'h9, 4'h1, 4'h1, 4'h0, 32'h0000_000A, 32'h0000_0000);
    dec(16'h0009, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 32'h0000_0000, 32'h0000_0000);
    dec(16'hFFFF, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0, 32'h0000_0000, 32'h0000_0000);
    check({31'h0000_0000, illegal}, 32'h0000_0001);
  endtask : t_misc

  // Remaining addressing classes and the arithmetic group
  task automatic t_modes();
    dec(16'h6126, 4'h3, 4'h3, 4'h1, 4'h1, 4'h2, 32'h0000_0000, 32'h0000_0000);
    dec(16'h2126, 4'h3, 4'h1, 4'h4, 4'h1, 4'h2, 32'h0000_0000, 32'h0000_0000);
    dec(16'h3120, 4'h3, 4'h1, 4'h1, 4'h1, 4'h2, 32'h0000_0000, 32'h0000_0000);
    dec(16'h3123, 4'h3, 4'h1, 4'h1, 4'h1, 4'h2, 32'h0000_0000, 32'h0000_0000);
    dec(16'h3121, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0, 32'h0000_0000, 32'h0000_0000);
    dec(16'h012C, 4'h3, 4'h5, 4'h1, 4'h1, 4'h2, 32'h0000_0000, 32'h0000_0000);
    check({30'h0000_0000, size}, 32'h0000_0000);
    dec(16'h010A, 4'h1, 4'hC, 4'h1, 4'h1, 4'h0, 32'h0000_0000, 32'h0000_0000);
    dec(16'hCD0F, 4'hA, 4'hB, 4'h8, 4'h0, 4'h0, 32'h0000_0000, 32'h0000_000F);
    dec(16'hC7FF, 4'h7, 4'h9, 4'h1, 4'h0, 4'h0, 32'h0000_03FC, 32'h0000_0000);
  endtask : t_modes

  // Words are decoded even when not qualified
  task automatic t_valid();
    i_fetch.present(16'h7105, 1'b0);
    @(posedge mclk);
    #1;
    check({27'h000_0000, valid, fmt}, {27'h000_0000, 1'b0, 4'hB});
    i_fetch.idle();
    @(posedge mclk);
    #1;
  endtask : t_valid

  // Reset in mid-run loads the reset values into the registered outputs at once
  task automatic t_reset();
    i_fetch.present(16'h7105, 1'b1);
    reset = 1'b1;
    #10;
    check({26'h000_0000, valid, illegal, fmt}, {26'h000_0000, 1'b0, 1'b1, 4'hF});
    @(posedge mclk);
    #1;
    reset = 1'b0;
    dec(16'h7105, 4'hB, 4'hB, 4'h1, 4'h1, 4'h0, 32'h0000_0000, 32'h0000_0005);
  endtask : t_reset

  // Main sequence
  initial begin
    reset = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    reset = 1'b0;
    t_ni();
    t_imm();
    t_branch();
    t_ctrl();
    t_nm();
    t_disp();
    t_misc();
    t_modes();
    t_valid();
    t_reset();
    conclude();
  end

  // Watchdog far beyond the expected run
  initial begin
    #200_000;
    err_total++;
    conclude();
  end
endmodule : risc_instruction_format_decoder_bench
`default_nettype wire
